// file: logic/keyed_watchdog_timer.sv
/*
  Keyed watchdog: 16-bit counter on a slow time base, control register
  guarded by a two-byte key sequence, reset-cause flag and event interrupt.
  Assumes an Avalon-MM master with byte addresses and a single system clock.
*/
`timescale 1ns/1ps
module keyed_watchdog_timer #(
  parameter int OSC_DIV = wdog_pkg::OSC_DIV
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [wdog_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic cpu_reset_req,
  output logic irq
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n;

  // Assert at once, release two edges later
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic ack_r;
  logic wr_acc;
  logic [7:0] wbyte;
  logic hit_key;
  logic hit_ctl;
  logic hit_sys;
  logic hit_sts;
  logic hit_msk;

  // One wait state on every access; writes land on the releasing edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (read | write) & ~ack_r;
    end
  end

  assign waitrequest = (read | write) & ~ack_r;
  assign wr_acc = write & ack_r & byteenable[0];
  assign wbyte = writedata[7:0];

  // Address decode
  always_comb begin
    hit_key = 1'b0;
    hit_ctl = 1'b0;
    hit_sys = 1'b0;
    hit_sts = 1'b0;
    hit_msk = 1'b0;
    if (address == {wdog_pkg::IDX_UNLOCK_KEY, 2'b00}) begin
      hit_key = 1'b1;
    end else if (address == {wdog_pkg::IDX_CONTROL, 2'b00}) begin
      hit_ctl = 1'b1;
    end else if (address == {wdog_pkg::IDX_SYS_CONTROL, 2'b00}) begin
      hit_sys = 1'b1;
    end else if (address == {wdog_pkg::IDX_IRQ_STATUS, 2'b00}) begin
      hit_sts = 1'b1;
    end else if (address == {wdog_pkg::IDX_IRQ_MASK, 2'b00}) begin
      hit_msk = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Key sequence detector
  // ----------------------------------------------------------------
  wdog_pkg::key_state_type key_state_r;
  logic unlocked_r;
  logic key_wr;
  logic key_err;

  assign key_wr = wr_acc & hit_key;
  // A byte written mid-pair that does not complete it, a restarting first byte included
  assign key_err = key_wr && (key_state_r != wdog_pkg::KEY_IDLE)
    && !((key_state_r == wdog_pkg::KEY_SEEN_A) && (wbyte == wdog_pkg::KEY_BYTE_B))
    && !((key_state_r == wdog_pkg::KEY_SEEN_B) && (wbyte == wdog_pkg::KEY_BYTE_A));

  // Only key-register writes advance or break a pair
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      key_state_r <= wdog_pkg::KEY_IDLE;
      unlocked_r <= 1'b0;
    end else if (key_wr) begin
      case (key_state_r)
        wdog_pkg::KEY_SEEN_A: begin
          if (wbyte == wdog_pkg::KEY_BYTE_B) begin
            unlocked_r <= 1'b1;
            key_state_r <= wdog_pkg::KEY_IDLE;
          end else begin
            key_state_r <= wdog_pkg::KEY_SEEN_A;
          end
        end
        wdog_pkg::KEY_SEEN_B: begin
          if (wbyte == wdog_pkg::KEY_BYTE_A) begin
            unlocked_r <= 1'b0;
            key_state_r <= wdog_pkg::KEY_IDLE;
          end else if (wbyte == wdog_pkg::KEY_BYTE_B) begin
            key_state_r <= wdog_pkg::KEY_SEEN_B;
          end else begin
            key_state_r <= wdog_pkg::KEY_IDLE;
          end
        end
        default: begin
          if (wbyte == wdog_pkg::KEY_BYTE_A) begin
            key_state_r <= wdog_pkg::KEY_SEEN_A;
          end else if (wbyte == wdog_pkg::KEY_BYTE_B) begin
            key_state_r <= wdog_pkg::KEY_SEEN_B;
          end else begin
            key_state_r <= wdog_pkg::KEY_IDLE;
          end
        end
      endcase
      // In SEEN_A any byte other than B falls to idle or restarts on A
      if ((key_state_r == wdog_pkg::KEY_SEEN_A) && (wbyte != wdog_pkg::KEY_BYTE_B)
          && (wbyte != wdog_pkg::KEY_BYTE_A)) begin
        key_state_r <= wdog_pkg::KEY_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register and counter
  // ----------------------------------------------------------------
  logic enable_r;
  logic [wdog_pkg::SEL_W-1:0] sel_r;
  logic [wdog_pkg::CNT_W-1:0] cnt_r;
  logic [wdog_pkg::CNT_W-1:0] cnt_top;
  logic ctl_wr;
  logic locked_wr;
  logic clr_req;
  logic tick;
  logic ovf;

  assign ctl_wr = wr_acc & hit_ctl & unlocked_r;
  assign locked_wr = wr_acc & hit_ctl & ~unlocked_r;
  assign clr_req = ctl_wr & wbyte[wdog_pkg::CTL_CLEAR_BIT];
  // Terminal count 2^(9+sel)-1, so each select step doubles the timeout
  assign cnt_top = wdog_pkg::CNT_W'((32'h1 << (wdog_pkg::SEL_BASE_LOG2 + 32'(sel_r))) - 32'h1);
  assign ovf = enable_r & tick & (cnt_r == cnt_top);

  osc_tick_gen #(
    .DIV(OSC_DIV)
  ) u_tick (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick(tick)
  );

  // Enable and select; overflow beats a same-cycle software write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enable_r <= wdog_pkg::CTL_ENABLE_RESET;
      sel_r <= wdog_pkg::CTL_SEL_RESET;
    end else if (ovf) begin
      enable_r <= 1'b0;
    end else if (ctl_wr) begin
      enable_r <= wbyte[wdog_pkg::CTL_ENABLE_BIT];
      sel_r <= wbyte[wdog_pkg::CTL_SEL_LSB +: wdog_pkg::SEL_W];
    end
  end

  // Counter advances once per time-base tick while enabled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (clr_req || ovf) begin
      cnt_r <= '0;
    end else if (enable_r && tick) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Reset request pulse; the processor reset does not touch this block
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpu_reset_req <= 1'b0;
    end else begin
      cpu_reset_req <= ovf;
    end
  end

  // ----------------------------------------------------------------
  // Reset-cause flag and interrupt
  // ----------------------------------------------------------------
  logic reset_flag_r;
  logic [wdog_pkg::IRQ_W-1:0] sts_r;
  logic [wdog_pkg::IRQ_W-1:0] msk_r;
  logic [wdog_pkg::IRQ_W-1:0] evt;

  assign evt = {locked_wr, key_err, ovf};

  // Flag survives the processor reset; set wins over write-one clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reset_flag_r <= 1'b0;
    end else if (ovf) begin
      reset_flag_r <= 1'b1;
    end else if (wr_acc && hit_sys && wbyte[wdog_pkg::SYS_RESET_FLAG_BIT]) begin
      reset_flag_r <= 1'b0;
    end
  end

  // Sticky event bits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sts_r <= '0;
    end else if (wr_acc && hit_sts) begin
      sts_r <= (sts_r & ~wbyte[wdog_pkg::IRQ_W-1:0]) | evt;
    end else begin
      sts_r <= sts_r | evt;
    end
  end

  // Mask register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      msk_r <= wdog_pkg::IRQ_MASK_RESET;
    end else if (wr_acc && hit_msk) begin
      msk_r <= wbyte[wdog_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(sts_r & msk_r);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Captured on the wait cycle so data stand at the releasing edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= '0;
    end else if (read && !ack_r) begin
      readdata <= '0;
      if (hit_ctl) begin
        // Clear bit always reads zero; readable when locked too
        readdata[wdog_pkg::CTL_ENABLE_BIT] <= enable_r;
        readdata[wdog_pkg::CTL_SEL_LSB +: wdog_pkg::SEL_W] <= sel_r;
      end else if (hit_sys) begin
        readdata[wdog_pkg::SYS_RESET_FLAG_BIT] <= reset_flag_r;
      end else if (hit_sts) begin
        readdata[wdog_pkg::IRQ_W-1:0] <= sts_r;
      end else if (hit_msk) begin
        readdata[wdog_pkg::IRQ_W-1:0] <= msk_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence ovf_s;
    ovf;
  endsequence

  sequence unlock_pair_s;
    key_wr && (key_state_r == wdog_pkg::KEY_SEEN_A) && (wbyte == wdog_pkg::KEY_BYTE_B);
  endsequence

  sequence lock_pair_s;
    key_wr && (key_state_r == wdog_pkg::KEY_SEEN_B) && (wbyte == wdog_pkg::KEY_BYTE_A);
  endsequence

  unlock_seq_a: assert property (unlock_pair_s |=> unlocked_r)
    else $error("key pair did not unlock control");
  lock_seq_a: assert property (lock_pair_s |=> !unlocked_r)
    else $error("key pair did not lock control");
  key_break_a: assert property (
    key_wr && (wbyte != wdog_pkg::KEY_BYTE_A) && (wbyte != wdog_pkg::KEY_BYTE_B)
    |=> (key_state_r == wdog_pkg::KEY_IDLE) && $stable(unlocked_r))
    else $error("stray key byte left detector armed");
  locked_write_a: assert property (
    locked_wr && !ovf |=> $stable(enable_r) && $stable(sel_r))
    else $error("locked control write took effect");
  overflow_reset_a: assert property (ovf_s |=> cpu_reset_req ##1 !cpu_reset_req)
    else $error("overflow did not give one reset pulse");
  cause_flag_a: assert property (ovf_s |=> reset_flag_r && !enable_r && (cnt_r == '0))
    else $error("overflow did not set flag and drop enable");
  clear_cnt_a: assert property (clr_req |=> (cnt_r == '0))
    else $error("clear bit did not zero counter");
  count_tick_a: assert property (
    enable_r && tick && !ovf && !clr_req |=> (cnt_r == $past(cnt_r) + 1'b1))
    else $error("enabled counter missed a tick");
  disabled_hold_a: assert property (!enable_r && !clr_req |=> $stable(cnt_r))
    else $error("disabled counter moved");
  timeout_sel_a: assert property (ovf |-> (cnt_r == cnt_top) && tick)
    else $error("overflow off the selected terminal count");
  tick_rate_a: assert property (tick |=> !tick [*2])
    else $error("time base ticks too fast");

endmodule

// file: logic/osc_tick_gen.sv
/*
  Time base for the watchdog: a one-cycle enable pulse at the rate of the
  independent low-speed oscillator, derived from the system clock.
  Assumes an asynchronous active-low reset already released cleanly.
*/
`timescale 1ns/1ps
module osc_tick_gen #(
  parameter int DIV = 100
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic tick
);

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] div_r;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // Free running: kept independent of the watchdog enable on purpose
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (div_r == LAST);
      if (div_r == LAST) begin
        div_r <= '0;
      end else begin
        div_r <= div_r + 1'b1;
      end
    end
  end

endmodule

// file: pkg/wdog_pkg.sv
/*
  Constants shared by the keyed watchdog: register indices, field positions,
  reset values, key bytes and timing figures.
  Assumes a 25 MHz system clock and an Avalon-MM slave with byte addresses.
*/
// Operation
// - Watchdog is a 16-bit counter ticking from a separate 250 kHz time base.
// - Counter overflow while enabled requests a processor reset.
// - Control is writable only after key bytes 0x1E then 0xE1.
// - Key bytes 0xE1 then 0x1E make the control register read-only again.
// - Control bit 7 enables the watchdog; zero keeps it stopped.
// - Enabled counter advances on every time-base tick; the timeout select sets its top count.
// - Writing one to control bit 5 zeroes the counter and restarts it.
// - Control bits 2:0 pick timeouts doubling from 2.05 ms up to 262.14 ms.
// - Overflow sets the reset flag in system control bit 7 and clears enable.
package wdog_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_UNLOCK_KEY = 8'h97;
  localparam logic [7:0] IDX_CONTROL = 8'h9F;
  localparam logic [7:0] IDX_SYS_CONTROL = 8'hA0;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hA1;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hA2;
  localparam int ADDR_W = 10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_CLEAR_BIT = 5;
  localparam int CTL_SEL_LSB = 0;
  localparam int SEL_W = 3;
  localparam int SYS_RESET_FLAG_BIT = 7;
  localparam logic [2:0] CTL_SEL_RESET = 3'h0;
  localparam logic CTL_ENABLE_RESET = 1'b0;

  // Interrupt status / mask layout
  localparam int IRQ_W = 3;
  localparam int IRQ_OVERFLOW_BIT = 0;
  localparam int IRQ_KEY_ERROR_BIT = 1;
  localparam int IRQ_LOCKED_WRITE_BIT = 2;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Key bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY_BYTE_A = 8'h1E;
  localparam logic [7:0] KEY_BYTE_B = 8'hE1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 25000000;
  localparam int OSC_FREQ_HZ = 250000;
  localparam int OSC_DIV = CLK_FREQ_HZ / OSC_FREQ_HZ;
  localparam int CNT_W = 16;
  // Shortest timeout spans 2^9 time-base ticks (about 2.05 ms)
  localparam int SEL_BASE_LOG2 = 9;

  // ----------------------------------------------------------------
  // Key sequence detector states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_SEEN_A,
    KEY_SEEN_B
  } key_state_type;

endpackage

// file: verification/keyed_watchdog_timer_test.sv
/*
  Self-checking bench for the keyed watchdog: register access, key sequences,
  overflow timing, reset flag, clear, interrupt status and mask.
  Assumes the design answers each bus request after one wait cycle.
*/
`timescale 1ns/1ps
module keyed_watchdog_timer_test;
  // ------------------------------------------------------------
  // Settings and signals
  // ------------------------------------------------------------
  // Short time base keeps the overflow runs to a few thousand cycles
  localparam int DIV = 4;
  localparam int LIMIT = 30000;
  localparam logic [7:0] KEY = wdog_pkg::IDX_UNLOCK_KEY;
  localparam logic [7:0] CTL = wdog_pkg::IDX_CONTROL;
  localparam logic [7:0] SYS = wdog_pkg::IDX_SYS_CONTROL;
  localparam logic [7:0] STA = wdog_pkg::IDX_IRQ_STATUS;
  localparam logic [7:0] MSK = wdog_pkg::IDX_IRQ_MASK;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [wdog_pkg::ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic cpu_reset_req;
  logic irq;
  logic wait_s = 1'b1;
  logic [31:0] data_s = 32'h0;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;
  int pulses = 0;
  int n;
  int p0;
  integer seed = 32'hDB5C81E7;
  logic [7:0] rv;
  logic [31:0] lane_q;

  always #20 clk_sys = ~clk_sys;

  keyed_watchdog_timer #(.OSC_DIV(DIV)) dut_u (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .byteenable(byteenable),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .cpu_reset_req(cpu_reset_req),
    .irq(irq)
  );

  // Pre-edge copies, so the master never races the slave's own updates
  always @(negedge clk_sys) begin
    wait_s <= waitrequest;
    data_s <= readdata;
    if (cpu_reset_req === 1'b1) pulses <= pulses + 1;
  end

  // Hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_total++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic wrap_up;
    $display("Checks %0d, errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One Avalon transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    address <= {idx, 2'b00};
    write <= wr;
    read <= !wr;
    writedata <= {24'h0, d};
    byteenable <= be;
    do @(posedge clk_sys); while (wait_s !== 1'b0);
    q = data_s;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, 4'hF, q);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input string what);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, 4'hF, q);
    chk(q, {24'h0, e}, what);
  endtask

  // Timeout in system clocks for a select value
  function automatic int tout(input int sel);
    return (512 << sel) * DIV;
  endfunction

  // Enable with clear, then time the reset request pulse
  task automatic ovf(input logic [2:0] sel);
    wr(CTL, 8'hA0 | {5'h0, sel});
    n = 0;
    p0 = pulses;
    while (pulses == p0) begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(n >= tout(sel) - DIV - 2 && n <= tout(sel) + 4), 32'h1, "timeout length");
    repeat (3) @(posedge clk_sys);
    chk(32'(pulses - p0), 32'h1, "single reset pulse");
    rd(CTL, {5'h0, sel}, "enable cleared");
    rd(SYS, 8'h80, "reset flag");
    wr(SYS, 8'h80);
    rd(STA, 8'h01, "overflow status");
    chk({31'h0, irq}, 32'h1, "overflow irq");
    wr(STA, 8'h01);
    chk({31'h0, irq}, 32'h0, "irq after clear");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(KEY, 8'h00, "key reads zero");
    rd(CTL, 8'h00, "control reset");
    rd(SYS, 8'h00, "flag reset");
    rd(STA, 8'h00, "status reset");
    rd(MSK, 8'h00, "mask reset");
    rd(8'h00, 8'h00, "unmapped low");
    rd(8'hFF, 8'h00, "unmapped high");
    // Locked write is dropped and flagged
    wr(CTL, 8'h87);
    rd(CTL, 8'h00, "locked write");
    rd(STA, 8'h04, "locked status");
    chk({31'h0, irq}, 32'h0, "masked irq");
    wr(MSK, 8'h07);
    chk({31'h0, irq}, 32'h1, "unmasked irq");
    wr(STA, 8'h04);
    rd(STA, 8'h00, "status cleared");
    // Broken pair keeps the lock
    rv = 8'($random(seed));
    if (rv == 8'h1E || rv == 8'hE1) rv = 8'h55;
    wr(KEY, 8'h1E);
    wr(KEY, rv);
    wr(KEY, 8'hE1);
    wr(CTL, 8'h81);
    rd(CTL, 8'h00, "broken sequence");
    rd(STA, 8'h06, "key error status");
    wr(STA, 8'h06);
    // Pending 0xE1 pairs with the first 0x1E as a lock; the repeated 0x1E restarts
    wr(KEY, 8'h1E);
    wr(KEY, 8'h1E);
    wr(KEY, 8'h1E);
    wr(KEY, 8'hE1);
    rd(STA, 8'h02, "restart status");
    wr(STA, 8'h02);
    for (int i = 0; i < 8; i++) begin
      rv = 8'($random(seed));
      wr(CTL, rv & 8'h7F);
      rd(CTL, rv & 8'h07, "unlocked write");
    end
    // Write with lane 0 disabled is dropped
    bus(1'b1, CTL, 8'h02, 4'hE, lane_q);
    rd(CTL, rv & 8'h07, "byte lane off");
    wr(CTL, 8'h02);
    wr(KEY, 8'hE1);
    wr(KEY, 8'h1E);
    wr(CTL, 8'h85);
    rd(CTL, 8'h02, "relocked");
    wr(STA, 8'h04);
    wr(KEY, 8'h1E);
    wr(KEY, 8'hE1);
    wr(MSK, 8'h01);
    ovf(3'h0);
    // Periodic clears keep the counter short of the top
    wr(CTL, 8'h80);
    p0 = pulses;
    for (int i = 0; i < 4; i++) begin
      repeat (tout(0) * 3 / 4) @(posedge clk_sys);
      wr(CTL, 8'hA0);
    end
    chk(32'(pulses - p0), 32'h0, "cleared in time");
    wr(CTL, 8'h00);
    repeat (tout(0) + 50) @(posedge clk_sys);
    chk(32'(pulses - p0), 32'h0, "disabled no reset");
    ovf(3'h1);
    wrap_up();
  end
endmodule
